// ---- common/sfpe_pkg.sv ----
// What this block does
// - Status bit 7 reads 1 when idle
// - Parked clock: ready flag driven live
// - Busy during every internal array operation
// - Status bit 6 is never set, always reads 0
// - Status bits 5 to 2 fixed density code
// - Buffer write: 84H, 15 pad, 9-bit index
// - Buffer pointer increments per byte, wraps
// - Bytes stored until chip select rises
// - 83H: erase page, then program buffer
// - 88H: program page from buffer, no erase
// - Host programs unerased-free pages only
// - Host avoids repeated programs without erase
// - 81H: erase chosen page to ones
// - 50H: erase all eight block pages
// - Block number is upper six page bits
// - 82H: page, buffer index, then data
// - 82H end: erase page, program buffer
// - Everything shifted most significant bit first
// - Input on rising clock, output on falling
// - 57H or D7H streams status repeatedly
// - Deselected: input ignored, output released
package sfpe_pkg;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_BUF_WRITE = 8'h84;
  localparam logic [7:0] OP_PROG_ERASE = 8'h83;
  localparam logic [7:0] OP_PROG_NOERASE = 8'h88;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_PROG_THRU_BUF = 8'h82;
  localparam logic [7:0] OP_STATUS_A = 8'h57;
  localparam logic [7:0] OP_STATUS_B = 8'hD7;
  // ----------------------------------------
  // Frame layout and geometry
  // ----------------------------------------
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam logic [5:0] BYTE_END = 6'h28;
  localparam int PAGE_W = 9;
  localparam int COL_W = 9;
  localparam int BUF_BYTES = 264;
  localparam logic [2:0] LAST_PG_OFF = 3'h7;
  // ----------------------------------------
  // Self-timed operation lengths
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int ERASE_PROGRAM_TIME_US = 20;
  localparam int PROGRAM_TIME_US = 12;
  localparam int PAGE_ERASE_TIME_US = 8;
  localparam int BLOCK_ERASE_TIME_US = 32;
  localparam int ERASE_PROGRAM_CYCLES = ERASE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
  localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_US * CLK_MHZ;
  localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int SCK_HALF_CYCLES = 4;
  // ----------------------------------------
  // Host controller registers
  // ----------------------------------------
  localparam logic [7:0] REG_OPCODE = 8'h00;
  localparam logic [7:0] REG_ADDRESS = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam logic [7:0] REG_TX_DATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [2:0] ACT_HEADER = 3'h1;
  localparam logic [2:0] ACT_SEND = 3'h2;
  localparam logic [2:0] ACT_READ = 3'h3;
  localparam logic [2:0] ACT_CLOSE = 3'h4;
  localparam logic [2:0] ACT_WAIT_READY = 3'h5;
  localparam int HST_BUSY_BIT = 0;
  localparam int HST_OPEN_BIT = 1;
  localparam int HST_RX_LSB = 8;

  // Opcode that streams the status byte
  function automatic logic is_status_op(input logic [7:0] op);
    return (op == OP_STATUS_A) || (op == OP_STATUS_B);
  endfunction : is_status_op
endpackage : sfpe_pkg

// ---- common/sfpe_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Four-wire command link
// ----------------------------------------
interface sfpe_link_if;
  logic cs_n; // Chip select, active low
  logic sck; // Serial clock, idles low
  logic si; // Host to device data
  logic so; // Device output value
  logic so_oe; // Device drives its output
  logic so_line; // Resolved output wire
  // Released output reads as pulled high
  assign so_line = so_oe ? so : 1'b1;
  modport host (output cs_n, output sck, output si, input so_line);
  modport device (input cs_n, input sck, input si, output so, output so_oe);
endinterface : sfpe_link_if
`default_nettype wire

// ---- core/sfpe_link_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Pin synchroniser and edge finder
// ----------------------------------------
module sfpe_link_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  output logic cs_n,
  output logic si,
  output logic sck_rise,
  output logic sck_fall,
  output logic cs_rise
);
  // Bit order: 2 = select, 1 = clock, 0 = data
  typedef struct packed {
    logic [2:0] meta; // First stage, read by second only
    logic [2:0] sync; // Second stage
    logic sck_prev; // Clock one cycle back
    logic cs_prev; // Select one cycle back
  } sfpe_sync_t;

  sfpe_sync_t s_q;
  sfpe_sync_t s_d;

  // Next state of the two stages and history
  always_comb begin
    s_d = s_q;
    s_d.meta = {cs_n_pin, sck_pin, si_pin};
    s_d.sync = s_q.meta;
    s_d.sck_prev = s_q.sync[1];
    s_d.cs_prev = s_q.sync[2];
  end

  // State register; select resets deselected
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.meta[2] <= 1'b1;
      s_q.sync[2] <= 1'b1;
      s_q.cs_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cs_n = s_q.sync[2];
  assign si = s_q.sync[0];
  assign sck_rise = s_q.sync[1] & ~s_q.sck_prev;
  assign sck_fall = ~s_q.sync[1] & s_q.sck_prev;
  assign cs_rise = s_q.sync[2] & ~s_q.cs_prev;
endmodule : sfpe_link_sync
`default_nettype wire

// ---- core/sfpe_flash_device.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Flash command sequencer, device end
// ----------------------------------------
module sfpe_flash_device #(
  parameter int BUF_BYTES = sfpe_pkg::BUF_BYTES,
  parameter int EP_CYCLES = sfpe_pkg::ERASE_PROGRAM_CYCLES,
  parameter int P_CYCLES = sfpe_pkg::PROGRAM_CYCLES,
  parameter int PE_CYCLES = sfpe_pkg::PAGE_ERASE_CYCLES,
  parameter int BE_CYCLES = sfpe_pkg::BLOCK_ERASE_CYCLES,
  // Density code value is arbitrary
  parameter logic [3:0] DENSITY_CODE = 4'h5
) (
  input wire logic clk,
  input wire logic reset,
  sfpe_link_if.device link,
  output logic ready,
  output logic arr_wr,
  output logic arr_and,
  output logic [sfpe_pkg::PAGE_W-1:0] arr_page,
  output logic [sfpe_pkg::COL_W-1:0] arr_col,
  output logic [7:0] arr_data
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (BUF_BYTES < 1 || BUF_BYTES > 512) begin : g_chk_buf
    $error("Buffer size must be 1 to 512 bytes");
  end
  if (EP_CYCLES <= 2 * BUF_BYTES || P_CYCLES <= BUF_BYTES ||
      PE_CYCLES <= BUF_BYTES || BE_CYCLES <= 8 * BUF_BYTES) begin : g_chk_time
    $error("Operation time shorter than its array walk");
  end
  if (EP_CYCLES > 65535 || P_CYCLES > 65535 ||
      PE_CYCLES > 65535 || BE_CYCLES > 65535) begin : g_chk_tmr
    $error("Operation time exceeds timer width");
  end

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  localparam logic [8:0] LAST_COL = 9'(BUF_BYTES - 1);

  // Internal operation phase
  typedef enum logic [1:0] {
    SFPE_IDLE = 2'b00,
    SFPE_ERASE = 2'b01,
    SFPE_PROG = 2'b11,
    SFPE_HOLD = 2'b10
  } sfpe_eng_t;

  typedef struct packed {
    logic [31:0] shift; // Incoming bits
    logic [5:0] bits; // Bits taken this frame
    logic [7:0] opcode; // Latched opcode
    logic store_on; // Data bytes go to buffer
    logic [8:0] wptr; // Buffer write pointer
    logic [8:0] cmd_page; // Page named by the frame
    logic status_on; // Status stream selected
    logic so_on; // Output driven
    logic [2:0] sbit; // Status bit being shown
    logic so; // Output value
    sfpe_eng_t eng; // Operation phase
    logic [7:0] job; // Opcode being executed
    logic [8:0] page; // Target page
    logic [2:0] pg_off; // Page within block
    logic [8:0] col; // Byte walk position
    logic [15:0] tmr; // Remaining busy time
    logic comp; // Compare flag, reset to 0, never written
    logic arr_wr; // Array write strobe
    logic arr_and; // Write clears bits only
    logic [8:0] arr_page; // Array page
    logic [8:0] arr_col; // Array byte
    logic [7:0] arr_data; // Array data
    logic [BUF_BYTES-1:0][7:0] buffer; // Page buffer
  } sfpe_dev_t;

  sfpe_dev_t s_q;
  sfpe_dev_t s_d;

  logic cs_n; // Synchronised select
  logic si; // Synchronised data
  logic sck_rise; // Clock rose
  logic sck_fall; // Clock fell
  logic cs_rise; // Select rose
  logic busy; // Operation in progress
  logic launch; // Start an operation now
  logic [7:0] status; // Live status byte
  logic [31:0] nshift; // Shift with new bit
  logic [5:0] nbits; // Bit count with new bit

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Opcodes that start a self-timed operation
  function automatic logic is_array_op(input logic [7:0] op);
    return (op == sfpe_pkg::OP_PROG_ERASE) || (op == sfpe_pkg::OP_PROG_NOERASE) ||
           (op == sfpe_pkg::OP_PAGE_ERASE) || (op == sfpe_pkg::OP_BLOCK_ERASE) ||
           (op == sfpe_pkg::OP_PROG_THRU_BUF);
  endfunction : is_array_op

  // Opcodes followed by buffer data
  function automatic logic loads_buffer(input logic [7:0] op);
    return (op == sfpe_pkg::OP_BUF_WRITE) || (op == sfpe_pkg::OP_PROG_THRU_BUF);
  endfunction : loads_buffer

  // Page from the address field
  function automatic logic [8:0] page_of(input logic [7:0] op, input logic [23:0] a);
    if (op == sfpe_pkg::OP_BLOCK_ERASE) begin
      return {a[17:12], 3'h0};
    end
    return a[17:9];
  endfunction : page_of

  // Busy length by opcode, less one
  function automatic logic [15:0] op_cycles(input logic [7:0] op);
    case (op)
      sfpe_pkg::OP_PROG_NOERASE: return 16'(P_CYCLES - 1);
      sfpe_pkg::OP_PAGE_ERASE: return 16'(PE_CYCLES - 1);
      sfpe_pkg::OP_BLOCK_ERASE: return 16'(BE_CYCLES - 1);
      default: return 16'(EP_CYCLES - 1);
    endcase
  endfunction : op_cycles

  // ----------------------------------------
  // Link front end
  // ----------------------------------------
  sfpe_link_sync i_sfpe_link_sync (
    .clk(clk),
    .reset(reset),
    .cs_n_pin(link.cs_n),
    .sck_pin(link.sck),
    .si_pin(link.si),
    .cs_n(cs_n),
    .si(si),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall),
    .cs_rise(cs_rise)
  );

  assign busy = (s_q.eng != SFPE_IDLE);
  assign status = {~busy, s_q.comp, DENSITY_CODE, 2'b00};
  assign nshift = {s_q.shift[30:0], si};
  assign nbits = s_q.bits + 6'h01;
  assign launch = cs_rise & ~busy & (s_q.bits >= sfpe_pkg::HDR_BITS) &
                  is_array_op(s_q.opcode);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.arr_wr = 1'b0;
    // Command shifting
    if (cs_n) begin
      // Deselected: drop frame, release output
      s_d.bits = '0;
      s_d.status_on = 1'b0;
      s_d.so_on = 1'b0;
      s_d.store_on = 1'b0;
    end else if (sck_rise) begin
      s_d.shift = nshift;
      s_d.bits = nbits;
      if (nbits == sfpe_pkg::OPC_BITS) begin
        // Opcode complete
        s_d.opcode = nshift[7:0];
        s_d.status_on = sfpe_pkg::is_status_op(nshift[7:0]);
        s_d.sbit = 3'h0;
      end
      if (nbits == sfpe_pkg::HDR_BITS) begin
        // Address field complete
        s_d.cmd_page = page_of(s_q.opcode, nshift[23:0]);
        s_d.wptr = nshift[8:0];
        s_d.store_on = loads_buffer(s_q.opcode) & ~busy;
      end
      if (nbits == sfpe_pkg::BYTE_END) begin
        // Data byte complete
        s_d.bits = sfpe_pkg::HDR_BITS;
        if (s_q.store_on) begin
          s_d.buffer[s_q.wptr] = nshift[7:0];
          s_d.wptr = (s_q.wptr == LAST_COL) ? 9'h000 : s_q.wptr + 9'h001;
        end
      end
    end else if (sck_fall && s_q.status_on) begin
      // Next status bit, wrapping 0 to 7
      s_d.so_on = 1'b1;
      s_d.sbit = s_q.sbit - 3'h1;
    end
    // Output follows live status even with clock parked
    s_d.so = status[s_d.sbit];
    // Operation engine
    case (s_q.eng)
      SFPE_IDLE: begin
        if (launch) begin
          // Busy from the launching select edge
          s_d.job = s_q.opcode;
          s_d.page = s_q.cmd_page;
          s_d.pg_off = 3'h0;
          s_d.col = 9'h000;
          s_d.tmr = op_cycles(s_q.opcode);
          s_d.eng = (s_q.opcode == sfpe_pkg::OP_PROG_NOERASE) ? SFPE_PROG : SFPE_ERASE;
        end
      end
      SFPE_ERASE: begin
        // Write ones across the page
        s_d.tmr = s_q.tmr - 16'h0001;
        s_d.arr_wr = 1'b1;
        s_d.arr_and = 1'b0;
        s_d.arr_page = s_q.page | {6'h00, s_q.pg_off};
        s_d.arr_col = s_q.col;
        s_d.arr_data = 8'hFF;
        s_d.col = s_q.col + 9'h001;
        if (s_q.col == LAST_COL) begin
          s_d.col = 9'h000;
          if (s_q.job == sfpe_pkg::OP_BLOCK_ERASE && s_q.pg_off != sfpe_pkg::LAST_PG_OFF) begin
            s_d.pg_off = s_q.pg_off + 3'h1;
          end else if (s_q.job == sfpe_pkg::OP_PROG_ERASE ||
                       s_q.job == sfpe_pkg::OP_PROG_THRU_BUF) begin
            s_d.eng = SFPE_PROG;
          end else begin
            s_d.eng = SFPE_HOLD;
          end
        end
      end
      SFPE_PROG: begin
        // Copy buffer into the page
        s_d.tmr = s_q.tmr - 16'h0001;
        s_d.arr_wr = 1'b1;
        s_d.arr_and = (s_q.job == sfpe_pkg::OP_PROG_NOERASE);
        s_d.arr_page = s_q.page;
        s_d.arr_col = s_q.col;
        s_d.arr_data = s_q.buffer[s_q.col];
        s_d.col = s_q.col + 9'h001;
        if (s_q.col == LAST_COL) begin
          s_d.eng = SFPE_HOLD;
        end
      end
      SFPE_HOLD: begin
        // Remain busy for the rest of the time
        if (s_q.tmr == 16'h0000) begin
          s_d.eng = SFPE_IDLE;
        end else begin
          s_d.tmr = s_q.tmr - 16'h0001;
        end
      end
      default: begin
        s_d.eng = SFPE_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.so = s_q.so;
  assign link.so_oe = s_q.so_on;
  assign ready = ~busy;
  assign arr_wr = s_q.arr_wr;
  assign arr_and = s_q.arr_and;
  assign arr_page = s_q.arr_page;
  assign arr_col = s_q.arr_col;
  assign arr_data = s_q.arr_data;
endmodule : sfpe_flash_device
`default_nettype wire

// ---- core/sfpe_flash_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Flash command sequencer, host end
// ----------------------------------------
module sfpe_flash_host #(
  parameter int SCK_HALF = sfpe_pkg::SCK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sfpe_link_if.host link
);
  if (SCK_HALF < 4 || SCK_HALF > 127) begin : g_chk_half
    $error("Clock half period must be 4 to 127 cycles");
  end

  localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);
  localparam logic [7:0] SETTLE = 8'(2 * SCK_HALF);

  // Link phase
  typedef enum logic [1:0] {
    SFPE_H_IDLE = 2'b00,
    SFPE_H_LOW = 2'b01,
    SFPE_H_HIGH = 2'b11,
    SFPE_H_WAIT = 2'b10
  } sfpe_hph_t;

  typedef struct packed {
    sfpe_hph_t eng; // Link phase
    logic [7:0] opcode; // Opcode register
    logic [23:0] address; // Address register
    logic [7:0] tx; // Byte to send
    logic [7:0] rx; // Last byte received
    logic [31:0] shift; // Outgoing bits
    logic [5:0] left; // Bits still to clock
    logic [7:0] div; // Half period divider
    logic cs_n; // Select pin
    logic sck; // Clock pin
    logic si; // Data pin
    logic so_meta; // First sync stage
    logic so_sync; // Second sync stage
    logic [31:0] prdata; // Read data
  } sfpe_hst_t;

  sfpe_hst_t s_q;
  sfpe_hst_t s_d;
  logic access; // Access phase
  logic busy; // Link transfer running
  logic mapped; // Address hits a register
  logic [2:0] action; // Control action written

  assign access = psel & penable;
  assign busy = (s_q.eng != SFPE_H_IDLE);
  assign action = pwdata[2:0];
  assign mapped = (paddr == sfpe_pkg::REG_OPCODE) || (paddr == sfpe_pkg::REG_ADDRESS) ||
                  (paddr == sfpe_pkg::REG_CONTROL) || (paddr == sfpe_pkg::REG_TX_DATA) ||
                  (paddr == sfpe_pkg::REG_STATUS);
  assign pready = 1'b1;
  // Unmapped, or a control write while the link is busy
  assign pslverr = access & (~mapped |
                   (pwrite & busy & (paddr == sfpe_pkg::REG_CONTROL)));

  // Next state: link engine, then register access
  always_comb begin
    s_d = s_q;
    s_d.so_meta = link.so_line;
    s_d.so_sync = s_q.so_meta;
    case (s_q.eng)
      SFPE_H_IDLE: begin
        s_d.div = HALF_M1;
      end
      SFPE_H_LOW: begin
        // Present data while clock is low
        s_d.si = s_q.shift[31];
        if (s_q.div == 8'h00) begin
          s_d.sck = 1'b1;
          s_d.div = HALF_M1;
          s_d.eng = SFPE_H_HIGH;
        end else begin
          s_d.div = s_q.div - 8'h01;
        end
      end
      SFPE_H_HIGH: begin
        if (s_q.div == 8'h00) begin
          // Sample output before the falling edge
          s_d.rx = {s_q.rx[6:0], s_q.so_sync};
          s_d.sck = 1'b0;
          s_d.shift = {s_q.shift[30:0], 1'b0};
          s_d.left = s_q.left - 6'h01;
          s_d.div = HALF_M1;
          s_d.eng = (s_q.left == 6'h01) ? SFPE_H_IDLE : SFPE_H_LOW;
        end else begin
          s_d.div = s_q.div - 8'h01;
        end
      end
      SFPE_H_WAIT: begin
        // Clock parked low; watch the ready flag
        if (s_q.div != 8'h00) begin
          s_d.div = s_q.div - 8'h01;
        end else if (s_q.so_sync) begin
          s_d.eng = SFPE_H_IDLE;
        end
      end
      default: begin
        s_d.eng = SFPE_H_IDLE;
      end
    endcase
    // Read data prepared in the setup cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        sfpe_pkg::REG_OPCODE: s_d.prdata = {24'h000000, s_q.opcode};
        sfpe_pkg::REG_ADDRESS: s_d.prdata = {8'h00, s_q.address};
        sfpe_pkg::REG_TX_DATA: s_d.prdata = {24'h000000, s_q.tx};
        sfpe_pkg::REG_STATUS: s_d.prdata = {16'h0000, s_q.rx, 6'h00, ~s_q.cs_n, busy};
        default: s_d.prdata = 32'h00000000;
      endcase
    end
    // Writes take effect in the access phase
    if (access && pwrite && !pslverr) begin
      case (paddr)
        sfpe_pkg::REG_OPCODE: s_d.opcode = pwdata[7:0];
        sfpe_pkg::REG_ADDRESS: s_d.address = pwdata[23:0];
        sfpe_pkg::REG_TX_DATA: s_d.tx = pwdata[7:0];
        sfpe_pkg::REG_CONTROL: begin
          case (action)
            sfpe_pkg::ACT_HEADER: begin
              // Opcode, then address unless status read
              s_d.cs_n = 1'b0;
              s_d.shift = {s_q.opcode, s_q.address};
              s_d.left = sfpe_pkg::is_status_op(s_q.opcode) ?
                         sfpe_pkg::OPC_BITS : sfpe_pkg::HDR_BITS;
              s_d.eng = SFPE_H_LOW;
            end
            sfpe_pkg::ACT_SEND: begin
              s_d.shift = {s_q.tx, 24'h000000};
              s_d.left = sfpe_pkg::OPC_BITS;
              s_d.eng = SFPE_H_LOW;
            end
            sfpe_pkg::ACT_READ: begin
              s_d.shift = 32'h00000000;
              s_d.left = sfpe_pkg::OPC_BITS;
              s_d.eng = SFPE_H_LOW;
            end
            sfpe_pkg::ACT_CLOSE: begin
              s_d.cs_n = 1'b1;
            end
            sfpe_pkg::ACT_WAIT_READY: begin
              s_d.div = SETTLE;
              s_d.eng = SFPE_H_WAIT;
            end
            default: begin
              s_d.eng = s_q.eng;
            end
          endcase
        end
        default: begin
          s_d.eng = s_d.eng;
        end
      endcase
    end
  end

  // State register; select resets high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
      s_q.so_meta <= 1'b1;
      s_q.so_sync <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign link.cs_n = s_q.cs_n;
  assign link.sck = s_q.sck;
  assign link.si = s_q.si;
endmodule : sfpe_flash_host
`default_nettype wire

// ---- test/sfpe_link_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Link and engine watcher
// ----------------------------------------
module sfpe_link_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_oe,
  input wire logic so_line,
  input wire logic ready,
  input wire logic arr_wr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sck_idle_a: assert property (cs_n |-> !sck) else $error("sck high while deselected");
  si_hold_a: assert property (sck && $past(sck) |-> $stable(si)) else $error("si moved");
  so_release_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe) else $error("so kept");
  quiet_idle_a: assert property (cs_n && $past(cs_n, 6) |-> !so_oe) else $error("so on");
  busy_launch_a: assert property ($fell(ready) |-> cs_n && !$past(cs_n, 8))
    else $error("busy without chip select rise");
  busy_hold_a: assert property ($fell(ready) |-> (!ready)[*8]) else $error("busy too short");
  write_busy_a: assert property (arr_wr |-> !ready) else $error("array write while ready");
  flag_live_a: assert property ($rose(ready) && !cs_n && so_oe && !sck |-> ##[1:8] so_line)
    else $error("parked ready flag not updated");
endmodule : sfpe_link_assertions
`default_nettype wire

// ---- test/serial_flash_program_erase_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_flash_program_erase_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, last_err, ready, arr_wr, arr_and;
  logic [8:0] arr_page, arr_col;
  logic [7:0] arr_data;
  logic [7:0] mem [512][264]; // Array image built from the write port
  int n_fail = 0;
  int num_checks = 0;
  sfpe_link_if link_bus ();
  sfpe_flash_host i_sfpe_flash_host (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_bus));
  sfpe_flash_device #(.EP_CYCLES(600), .P_CYCLES(300), .PE_CYCLES(300), .BE_CYCLES(2200))
    i_sfpe_flash_device (.clk(clk), .reset(reset), .link(link_bus), .ready(ready),
    .arr_wr(arr_wr), .arr_and(arr_and), .arr_page(arr_page), .arr_col(arr_col),
    .arr_data(arr_data));
  sfpe_link_assertions i_sfpe_link_assertions (.clk(clk), .reset(reset), .cs_n(link_bus.cs_n),
    .sck(link_bus.sck), .si(link_bus.si), .so_oe(link_bus.so_oe), .so_line(link_bus.so_line),
    .ready(ready), .arr_wr(arr_wr));
  always #5 clk = ~clk;
  // Program without erase can only clear bits
  always @(posedge clk) if (arr_wr) mem[arr_page][arr_col] <= arr_and ?
    (mem[arr_page][arr_col] & arr_data) : arr_data;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t saw %h wanted %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Control action, then poll until the link is idle
  task automatic act(input logic [2:0] code);
    logic [31:0] r;
    apb(1'b1, sfpe_pkg::REG_CONTROL, {29'h0, code}, r);
    r = 32'h1;
    while (r[sfpe_pkg::HST_BUSY_BIT] !== 1'b0) apb(1'b0, sfpe_pkg::REG_STATUS, 32'h0, r);
  endtask : act
  task automatic frame(input logic [7:0] op, input logic [23:0] ad, input logic shut);
    logic [31:0] r;
    apb(1'b1, sfpe_pkg::REG_OPCODE, {24'h0, op}, r);
    apb(1'b1, sfpe_pkg::REG_ADDRESS, {8'h0, ad}, r);
    act(sfpe_pkg::ACT_HEADER);
    if (shut) act(sfpe_pkg::ACT_CLOSE);
  endtask : frame
  task automatic send(input logic [7:0] b);
    logic [31:0] r;
    apb(1'b1, sfpe_pkg::REG_TX_DATA, {24'h0, b}, r);
    act(sfpe_pkg::ACT_SEND);
  endtask : send
  // Status byte read and its fixed fields
  task automatic status(input logic rdy);
    logic [31:0] r;
    frame(sfpe_pkg::OP_STATUS_A, 24'h0, 1'b0);
    act(sfpe_pkg::ACT_READ);
    act(sfpe_pkg::ACT_CLOSE);
    apb(1'b0, sfpe_pkg::REG_STATUS, 32'h0, r);
    chk(r[15:10], {rdy, 1'b0, 4'h5});
    chk({link_bus.cs_n, link_bus.sck, link_bus.so_line}, 3'h5);
  endtask : status
  task automatic wait_ready();
    frame(sfpe_pkg::OP_STATUS_B, 24'h0, 1'b0);
    act(sfpe_pkg::ACT_WAIT_READY);
    act(sfpe_pkg::ACT_CLOSE);
  endtask : wait_ready
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    logic [31:0] r;
    foreach (mem[p, c]) mem[p][c] = 8'h00;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    frame(sfpe_pkg::OP_PROG_THRU_BUF, {6'h00, 9'h005, 9'h106}, 1'b0);
    // Address register reads back; frame open, link idle
    apb(1'b0, sfpe_pkg::REG_ADDRESS, 32'h0, r);
    chk(r, 32'h00000B06);
    apb(1'b0, sfpe_pkg::REG_STATUS, 32'h0, r);
    chk(r[1:0], 2'h2);
    send(8'hA1);
    send(8'hB2);
    send(8'hC3);
    act(sfpe_pkg::ACT_CLOSE);
    status(1'b0);
    wait_ready();
    chk({mem[5][262], mem[5][263], mem[5][0], mem[5][1]}, 32'hA1B2C300);
    frame(sfpe_pkg::OP_PAGE_ERASE, {6'h00, 9'h006, 9'h000}, 1'b1);
    wait_ready();
    chk(mem[6][9], 8'hFF);
    frame(sfpe_pkg::OP_BUF_WRITE, {15'h7FFF, 9'h000}, 1'b0);
    // Second control write while the link shifts is refused
    apb(1'b1, sfpe_pkg::REG_TX_DATA, 32'h0000000F, r);
    apb(1'b1, sfpe_pkg::REG_CONTROL, {29'h0, sfpe_pkg::ACT_SEND}, r);
    apb(1'b1, sfpe_pkg::REG_CONTROL, {29'h0, sfpe_pkg::ACT_READ}, r);
    chk({31'h0, last_err}, 32'h1);
    act(3'h0);
    send(8'hF0);
    act(sfpe_pkg::ACT_CLOSE);
    frame(sfpe_pkg::OP_PROG_NOERASE, {6'h00, 9'h006, 9'h1FF}, 1'b1);
    wait_ready();
    chk({mem[6][0], mem[6][1], mem[6][263]}, 24'h0FF0B2);
    frame(sfpe_pkg::OP_PROG_ERASE, {6'h00, 9'h005, 9'h000}, 1'b1);
    wait_ready();
    chk({mem[5][0], mem[5][262], mem[5][2]}, 24'h0FA100);
    frame(sfpe_pkg::OP_BLOCK_ERASE, {6'h00, 6'h02, 12'hFFF}, 1'b1);
    wait_ready();
    chk({mem[16][0], mem[23][263], mem[24][0], mem[15][0]}, 32'hFFFF0000);
    status(1'b1);
    tally_and_finish();
  end
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule : serial_flash_program_erase_bench
`default_nettype wire
